// ---- core/fieldbus_defs.vh ----
// Purpose: Shared constants of the fieldbus holding-register write handler.
// Assumes: Frame addresses are the zero-based values carried on the wire.
// Notes: Area bounds are inclusive; sizes are in 16-bit words per item.
`ifndef FIELDBUS_DEFS_VH
`define FIELDBUS_DEFS_VH

`define BROADCAST_ADDR 8'h00
`define FC_WRITE_SINGLE 8'h06
`define FC_WRITE_MULTI 8'h10
`define EXC_FLAG 8'h80
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`define EXC_ILLEGAL_VALUE 8'h03

`define MAX_WRITE_QTY 16'h007B
`define MAX_WORDS 10'h07B
`define HDR_BYTES 9'h007
`define SINGLE_BYTES 9'h006
`define NORMAL_RESP_LEN 3'h6
`define EXC_RESP_LEN 3'h3

`define INT16_FIRST 16'h0BB8
`define INT16_LAST 16'h0F9F
`define INT32_FIRST 16'h0FA0
`define INT32_LAST 16'h1387
`define INT64_FIRST 16'h1388
`define INT64_LAST 16'h176F
`define FLOAT_FIRST 16'h1B58
`define FLOAT_LAST 16'h2327
`define DOUBLE_FIRST 16'h2328
`define DOUBLE_LAST 16'h270F
`define TEXT8_FIRST 16'h32C8
`define TEXT8_LAST 16'h36AF
`define TEXT16_FIRST 16'h36B0
`define TEXT16_LAST 16'h3A97

`endif

// ---- core/register_area_map.v ----
// Purpose: Checks a register range against the data-type areas and scales it to words.
// Assumes: Count is already limited to the legal write quantity.
// Notes: Purely combinational; the caller registers what it needs.
`include "fieldbus_defs.vh"

module register_area_map (
   input wire [15:0] start,
   input wire [6:0] count,
   input wire item_mode,
   input wire single,
   output reg legal,
   output reg [9:0] words,
   output reg [15:0] first_word
);

   reg [15:0] base;
   reg [15:0] last;
   reg [1:0] shift;
   reg found;
   reg text_area;
   reg [16:0] range_end;
   reg [15:0] offset;

   always @* begin
      base = 16'h0000;
      last = 16'h0000;
      shift = 2'd0;
      found = 1'b1;
      text_area = 1'b0;
      if (start >= `INT16_FIRST && start <= `INT16_LAST) begin
         base = `INT16_FIRST;
         last = `INT16_LAST;
         shift = 2'd0;
      end else if (start >= `INT32_FIRST && start <= `INT32_LAST) begin
         base = `INT32_FIRST;
         last = `INT32_LAST;
         shift = 2'd1;
      end else if (start >= `INT64_FIRST && start <= `INT64_LAST) begin
         base = `INT64_FIRST;
         last = `INT64_LAST;
         shift = 2'd2;
      end else if (start >= `FLOAT_FIRST && start <= `FLOAT_LAST) begin
         base = `FLOAT_FIRST;
         last = `FLOAT_LAST;
         shift = 2'd1;
      end else if (start >= `DOUBLE_FIRST && start <= `DOUBLE_LAST) begin
         base = `DOUBLE_FIRST;
         last = `DOUBLE_LAST;
         shift = 2'd2;
      end else if (start >= `TEXT8_FIRST && start <= `TEXT8_LAST) begin
         base = `TEXT8_FIRST;
         last = `TEXT8_LAST;
         shift = 2'd2;
         text_area = 1'b1;
      end else if (start >= `TEXT16_FIRST && start <= `TEXT16_LAST) begin
         base = `TEXT16_FIRST;
         last = `TEXT16_LAST;
         shift = 2'd3;
         text_area = 1'b1;
      end else begin
         found = 1'b0;
      end
      // In word mode every address is one word; in item mode one whole item.
      if (item_mode) begin
         words = {3'b000, count} << shift;
      end else begin
         words = {3'b000, count};
      end
      range_end = {1'b0, start} + {10'h000, count} - 17'h00001;
      offset = start - base;
      first_word = item_mode ? (base + (offset << shift)) : start;
      // Text items take no single-register write.
      legal = found && (range_end <= {1'b0, last}) && !(single && text_area);
   end

endmodule // register_area_map

// ---- core/fieldbus_write_handler.v ----
// Purpose: Executes holding-register writes from received frames and builds replies.
// Assumes: The framer gives bytes without checksum and flags frame end with its status.
// Notes: Writes are held back until the frame check passes; the framer adds the checksum.
`include "fieldbus_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Function 16 writes one to 123 contiguous holding registers per request.
// - A broadcast function 16 still writes the addressed registers.
// - Frame register addresses are zero-based; the first register is address zero.
// - Good write reply: address, function, start and quantity, high bytes first.
// - A good non-broadcast frame to this address that cannot be carried out gets an exception reply.
// - Broadcast requests never get any reply.
// - Frames with parity or check errors are dropped without any reply.
// - A normal reply copies the request function code unchanged.
// - An exception reply returns the function code with its top bit set.
// - Exception reply holds address, flagged function and one code byte only.
// - Code 01 for unsupported functions, code 02 for illegal register addresses.
// - The multiple-coil write function is not supported.
// - Wide types are changed only by the single and multiple register writes.
// - A select input picks counting mode; word mode counts 16-bit registers.
// - In item mode each address selects one whole data item.
// - In item mode a single-register write writes one whole item; text items refuse it with code 02.
// - Word mode item sizes are 1, 2, 4 or 8 registers; item mode 1.
// - The first float sits at 7000 and 7001, the next at 7002.
// - Eight and sixteen character text items live in their own areas.
// - Sixteen-bit values travel high byte first, then low byte.
// - Wire register numbers are one below the internal one-based numbers.
// - Broadcasts of functions without broadcast support are ignored silently.
module fieldbus_write_handler (
   input wire SYS_CLK,
   input wire RST_N,
   input wire [7:0] DEV_ADDR,
   input wire ADDRESS_COUNTING_SELECT,
   input wire [7:0] RX_BYTE,
   input wire RX_VALID,
   input wire RX_END,
   input wire RX_GOOD,
   input wire TX_READY,
   output reg [7:0] TX_BYTE,
   output reg TX_VALID,
   output reg TX_LAST,
   output reg WR_EN,
   output reg [15:0] WR_ADDR,
   output reg [15:0] WR_DATA,
   output reg BUSY
);

   localparam [1:0] ST_COLLECT = 2'b00;
   localparam [1:0] ST_WRITE = 2'b01;
   localparam [1:0] ST_REPLY = 2'b10;

   reg [1:0] state;
   reg [8:0] byte_idx;
   reg overflow;
   reg [7:0] rx_addr;
   reg [7:0] rx_func;
   reg [15:0] start_addr;
   reg [15:0] quantity;
   reg [7:0] byte_count;
   reg [15:0] data_mem [0:122];
   reg [9:0] word_total;
   reg [15:0] word_base;
   reg [9:0] word_idx;
   reg is_single;
   reg silent;
   reg [7:0] exc_code;
   reg [2:0] tx_len;
   reg [2:0] tx_idx;
   reg [7:0] reply_byte;

   wire item_mode = ADDRESS_COUNTING_SELECT;
   wire map_legal;
   wire [9:0] map_words;
   wire [15:0] map_first;
   wire single_req = (rx_func == `FC_WRITE_SINGLE);
   wire multi_req = (rx_func == `FC_WRITE_MULTI);
   wire is_bcast = (rx_addr == `BROADCAST_ADDR);
   wire for_us = (rx_addr == DEV_ADDR) || is_bcast;
   wire [8:0] data_pos = byte_idx - `HDR_BYTES;
   wire qty_ok = (quantity != 16'h0000) && (quantity <= `MAX_WRITE_QTY);
   wire [6:0] map_count = single_req ? 7'h01 : quantity[6:0];

   ////////////////////////////////////////////////////////////////////////////
   // Start address is used exactly as received, already zero-based.
   register_area_map u_area_map (
      .start(start_addr),
      .count(map_count),
      .item_mode(item_mode),
      .single(single_req),
      .legal(map_legal),
      .words(map_words),
      .first_word(map_first)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Data staging. Words land here first so that a frame failing its check
   // never touches the application registers.
   genvar gi;
   generate
      for (gi = 0; gi < 123; gi = gi + 1) begin : g_stage
         always @(posedge SYS_CLK) begin
            if (!RST_N) begin
               data_mem[gi] <= 16'h0000;
            end else if (state == ST_COLLECT && RX_VALID && multi_req &&
                         byte_idx >= `HDR_BYTES && data_pos[8:1] == gi) begin
               if (!data_pos[0]) begin
                  data_mem[gi][15:8] <= RX_BYTE;
               end else begin
                  data_mem[gi][7:0] <= RX_BYTE;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Frame-end decision, evaluated when the framer reports the end.
   reg take;
   reg reply_exc;
   reg [7:0] next_exc;
   reg format_ok;

   always @* begin
      take = 1'b0;
      reply_exc = 1'b0;
      next_exc = 8'h00;
      format_ok = 1'b0;
      if (single_req) begin
         format_ok = (byte_idx == `SINGLE_BYTES);
      end else begin
         // The byte count must cover every word written, two bytes per word; in item
         // mode that is the scaled word count, not the item quantity.
         format_ok = !overflow && qty_ok && (map_words <= `MAX_WORDS) &&
                     ({1'b0, byte_count} == {map_words[7:0], 1'b0}) &&
                     (map_words[9:8] == 2'b00) &&
                     (byte_idx == `HDR_BYTES + {1'b0, byte_count});
      end
      // A frame that failed its check, or is meant for another slave, leaves no trace:
      // the master's response timeout is the only way it learns of the loss.
      if (!RX_GOOD || byte_idx < 9'h002 || !for_us) begin
         take = 1'b0;
      end else if (!single_req && !multi_req) begin
         // Coil writes, reads and all else are not ours to execute.
         reply_exc = !is_bcast;
         next_exc = `EXC_ILLEGAL_FUNCTION;
      end else if (!format_ok) begin
         reply_exc = !is_bcast;
         next_exc = `EXC_ILLEGAL_VALUE;
      end else if (!map_legal) begin
         reply_exc = !is_bcast;
         next_exc = `EXC_ILLEGAL_ADDRESS;
      end else begin
         take = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reply byte selection; all 16-bit fields go high byte first.
   always @* begin
      reply_byte = 8'h00;
      // No valid exception code is zero, so a zero code marks a normal reply and
      // the function byte then goes back unchanged.
      case (tx_idx)
         3'd0: reply_byte = rx_addr;
         3'd1: reply_byte = (exc_code != 8'h00) ? (rx_func | `EXC_FLAG) : rx_func;
         3'd2: reply_byte = (exc_code != 8'h00) ? exc_code : start_addr[15:8];
         3'd3: reply_byte = start_addr[7:0];
         3'd4: reply_byte = quantity[15:8];
         3'd5: reply_byte = quantity[7:0];
         default: reply_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer.
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state <= ST_COLLECT;
         byte_idx <= 9'h000;
         overflow <= 1'b0;
         rx_addr <= 8'h00;
         rx_func <= 8'h00;
         start_addr <= 16'h0000;
         quantity <= 16'h0000;
         byte_count <= 8'h00;
         word_total <= 10'h000;
         word_base <= 16'h0000;
         word_idx <= 10'h000;
         is_single <= 1'b0;
         silent <= 1'b0;
         exc_code <= 8'h00;
         tx_len <= 3'd0;
         tx_idx <= 3'd0;
         TX_BYTE <= 8'h00;
         TX_VALID <= 1'b0;
         TX_LAST <= 1'b0;
         WR_EN <= 1'b0;
         WR_ADDR <= 16'h0000;
         WR_DATA <= 16'h0000;
         BUSY <= 1'b0;
      end else begin
         WR_EN <= 1'b0;
         case (state)
            ST_COLLECT: begin
               if (RX_END) begin
                  byte_idx <= 9'h000;
                  overflow <= 1'b0;
                  word_total <= map_words;
                  word_base <= map_first;
                  word_idx <= 10'h000;
                  is_single <= single_req;
                  silent <= is_bcast;
                  exc_code <= next_exc;
                  tx_idx <= 3'd0;
                  // Exception replies end after the code byte, normal ones after the quantity.
                  tx_len <= reply_exc ? `EXC_RESP_LEN : `NORMAL_RESP_LEN;
                  if (take) begin
                     state <= ST_WRITE;
                     BUSY <= 1'b1;
                  end else if (reply_exc) begin
                     state <= ST_REPLY;
                     BUSY <= 1'b1;
                  end
               end else if (RX_VALID) begin
                  // The counter saturates instead of wrapping, so an endless stream can
                  // never pass for a short legal frame.
                  if (byte_idx == 9'h1FF) begin
                     overflow <= 1'b1;
                  end else begin
                     byte_idx <= byte_idx + 9'h001;
                  end
                  if (byte_idx == 9'h000) begin
                     rx_addr <= RX_BYTE;
                  end else if (byte_idx == 9'h001) begin
                     rx_func <= RX_BYTE;
                  end else if (byte_idx == 9'h002) begin
                     start_addr[15:8] <= RX_BYTE;
                  end else if (byte_idx == 9'h003) begin
                     start_addr[7:0] <= RX_BYTE;
                  end else if (byte_idx == 9'h004) begin
                     quantity[15:8] <= RX_BYTE;
                  end else if (byte_idx == 9'h005) begin
                     quantity[7:0] <= RX_BYTE;
                  end else if (byte_idx == 9'h006) begin
                     byte_count <= RX_BYTE;
                  end
                  // More data than the staging holds can never be legal.
                  if (byte_idx >= `HDR_BYTES && data_pos[8:1] > 8'd122) begin
                     overflow <= 1'b1;
                  end
               end
            end
            ST_WRITE: begin
               WR_EN <= 1'b1;
               WR_ADDR <= word_base + {6'h00, word_idx};
               if (!is_single) begin
                  WR_DATA <= data_mem[word_idx[6:0]];
               end else if (word_idx == word_total - 10'h001) begin
                  // The value goes to the least significant word of the item.
                  WR_DATA <= quantity;
               end else begin
                  WR_DATA <= 16'h0000;
               end
               if (word_idx == word_total - 10'h001) begin
                  // Even a broadcast passes through the reply state, so that BUSY
                  // still stands while the last write pulse is out.
                  state <= ST_REPLY;
               end else begin
                  word_idx <= word_idx + 10'h001;
               end
            end
            ST_REPLY: begin
               // A broadcast leaves here at once: nothing may go back on the link,
               // since the master expects no answer from any slave.
               if (silent) begin
                  state <= ST_COLLECT;
                  BUSY <= 1'b0;
               end else if (!TX_VALID || TX_READY) begin
                  if (tx_idx == tx_len) begin
                     TX_VALID <= 1'b0;
                     TX_LAST <= 1'b0;
                     state <= ST_COLLECT;
                     BUSY <= 1'b0;
                  end else begin
                     TX_VALID <= 1'b1;
                     TX_BYTE <= reply_byte;
                     TX_LAST <= (tx_idx == tx_len - 3'd1);
                     tx_idx <= tx_idx + 3'd1;
                  end
               end
            end
            default: begin
               state <= ST_COLLECT;
               BUSY <= 1'b0;
            end
         endcase
      end
   end

endmodule // fieldbus_write_handler

// ---- dv/fieldbus_write_handler_monitor.sv ----
// Purpose: Port checker for the holding-register write handler.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Broadcast frames are told apart by the first byte of each frame.
module fieldbus_write_handler_monitor (
   input logic SYS_CLK,
   input logic RST_N,
   input logic [7:0] DEV_ADDR,
   input logic [7:0] RX_BYTE,
   input logic RX_VALID,
   input logic RX_END,
   input logic RX_GOOD,
   input logic TX_READY,
   input logic [7:0] TX_BYTE,
   input logic TX_VALID,
   input logic TX_LAST,
   input logic WR_EN,
   input logic [15:0] WR_ADDR,
   input logic BUSY
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   logic in_frame, bcast, last_acc;
   logic [7:0] head;
   ////////////////////////////////////////////////////////////
   // Bytes offered while busy are ignored by the handler, so they never open a frame here.
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         in_frame <= 1'b0;
         bcast <= 1'b0;
         head <= 8'h00;
         last_acc <= 1'b0;
      end else begin
         last_acc <= TX_VALID && TX_READY && TX_LAST;
         if (RX_VALID && !BUSY && !in_frame) begin
            head <= RX_BYTE;
            bcast <= 1'b0;
         end
         if (RX_VALID && !BUSY) in_frame <= 1'b1;
         if (RX_END) begin
            in_frame <= 1'b0;
            bcast <= (head == 8'h00);
         end
      end
   end
   sequence s_stall; TX_VALID && !TX_READY; endsequence
   sequence s_wr_pair; WR_EN ##1 WR_EN; endsequence
   sequence s_wr_last; WR_EN ##1 !WR_EN; endsequence
   property p_tx_hold; s_stall |=> TX_VALID && $stable(TX_BYTE) && $stable(TX_LAST); endproperty
   property p_last_end; TX_VALID && TX_READY && TX_LAST |=> !TX_VALID ##1 !TX_VALID; endproperty
   property p_bad_drop; RX_END && !RX_GOOD && !BUSY |=> (!BUSY && !WR_EN) [*2]; endproperty
   property p_bcast_quiet; bcast |-> !TX_VALID; endproperty
   property p_wr_quiet; WR_EN |-> BUSY && !TX_VALID; endproperty
   property p_wr_step; s_wr_pair |-> WR_ADDR == $past(WR_ADDR) + 16'h0001; endproperty
   property p_reply_follows; s_wr_last |-> TX_VALID || bcast; endproperty
   property p_reply_head; $rose(TX_VALID) |-> TX_BYTE == DEV_ADDR; endproperty
   property p_done; $fell(BUSY) && !bcast |-> last_acc; endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("reply byte changed while stalled");
   a_last_end: assert property (p_last_end)
      else $error("reply continued past its last byte");
   a_bad_drop: assert property (p_bad_drop)
      else $error("corrupted frame was acted on");
   a_bcast_quiet: assert property (p_bcast_quiet)
      else $error("reply sent to a broadcast");
   a_wr_quiet: assert property (p_wr_quiet)
      else $error("reply overlaps register writes");
   a_wr_step: assert property (p_wr_step)
      else $error("written registers not contiguous");
   a_reply_follows: assert property (p_reply_follows)
      else $error("reply late after last write");
   a_reply_head: assert property (p_reply_head)
      else $error("reply does not start with own address");
   a_done: assert property (p_done)
      else $error("busy ended without a finished reply");
endmodule // fieldbus_write_handler_monitor

bind fieldbus_write_handler fieldbus_write_handler_monitor i_mon (.SYS_CLK, .RST_N, .DEV_ADDR,
   .RX_BYTE, .RX_VALID, .RX_END, .RX_GOOD, .TX_READY, .TX_BYTE, .TX_VALID, .TX_LAST, .WR_EN,
   .WR_ADDR, .BUSY);

// ---- dv/reply_sink.sv ----
// Purpose: Framer-side sink that accepts reply bytes from the handler.
// Assumes: Replies pass by a valid and ready handshake.
// Notes: Slow mode stalls two cycles in three to stress byte holding.
module reply_sink (
   input wire logic SYS_CLK,
   input logic [7:0] TX_BYTE,
   input logic TX_VALID,
   input logic TX_LAST,
   input logic slow,
   output logic TX_READY
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] q[$];
   int last_at;
   int tick;
   initial begin
      TX_READY = 1'b0;
      tick = 0;
      last_at = 0;
   end
   always @(negedge SYS_CLK) begin
      tick++;
      TX_READY <= !slow || (tick % 3 == 0);
   end
   always @(posedge SYS_CLK) begin
      if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
         q.push_back(TX_BYTE);
         if (TX_LAST === 1'b1) last_at = q.size();
      end
   end
endmodule // reply_sink

// ---- dv/test_fieldbus_write_handler.sv ----
// Purpose: Self-checking bench for the holding-register write handler.
// Assumes: The framer has stripped checksums; the sink takes the replies.
// Notes: Frame addresses are zero-based throughout.
module test_fieldbus_write_handler;
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [7:0] bq_t[$];
   typedef logic [31:0] wq_t[$];
   logic SYS_CLK, RST_N, ADDRESS_COUNTING_SELECT, RX_VALID, RX_END, RX_GOOD, slow;
   logic TX_READY, TX_VALID, TX_LAST, WR_EN, BUSY;
   logic [7:0] DEV_ADDR, RX_BYTE, TX_BYTE;
   logic [15:0] WR_ADDR, WR_DATA;
   wq_t wq;
   int err_total, n_compared;
   fieldbus_write_handler i_fieldbus_write_handler (.SYS_CLK, .RST_N, .DEV_ADDR,
      .ADDRESS_COUNTING_SELECT, .RX_BYTE, .RX_VALID, .RX_END, .RX_GOOD, .TX_READY, .TX_BYTE,
      .TX_VALID, .TX_LAST, .WR_EN, .WR_ADDR, .WR_DATA, .BUSY);
   reply_sink i_reply_sink (.SYS_CLK, .TX_BYTE, .TX_VALID, .TX_LAST, .slow, .TX_READY);
   initial begin
      SYS_CLK = 1'b0;
      forever #25 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) if (WR_EN === 1'b1) wq.push_back({WR_ADDR, WR_DATA});
   ////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic bq_t hd(input logic [7:0] a, fc, input logic [15:0] s, n);
      hd = '{a, fc, s[15:8], s[7:0], n[15:8], n[7:0]};
   endfunction
   function automatic bq_t mf(input logic [7:0] a, input logic [15:0] s, n,
                              input logic [7:0] bc, input bq_t d);
      mf = {hd(a, 8'h10, s, n), bc, d};
   endfunction
   task send(input bq_t f, input logic good);
      foreach (f[i]) begin
         @(negedge SYS_CLK);
         RX_VALID = 1'b1;
         RX_BYTE = f[i];
      end
      @(negedge SYS_CLK);
      RX_VALID = 1'b0;
      RX_END = 1'b1;
      RX_GOOD = good;
      @(negedge SYS_CLK);
      RX_END = 1'b0;
   endtask
   // A silent handler is judged like a master's response timeout: bounded wait, then compare.
   task run(input bq_t f, input logic good, input bq_t er, input wq_t ew);
      int n;
      wq.delete();
      i_reply_sink.q.delete();
      i_reply_sink.last_at = 0;
      send(f, good);
      n = 0;
      repeat (2) @(negedge SYS_CLK);
      while (BUSY !== 1'b0 && n < 1000) begin
         @(negedge SYS_CLK);
         n++;
      end
      repeat (2) @(negedge SYS_CLK);
      chk("busy", 32'h0000_0000, {31'h0000_0000, BUSY});
      chk("reply_len", 32'(er.size()), 32'(i_reply_sink.q.size()));
      chk("last_pos", 32'(er.size()), 32'(i_reply_sink.last_at));
      foreach (er[i]) chk("reply_byte", {24'h00_0000, er[i]}, {24'h00_0000, i_reply_sink.q[i]});
      chk("write_count", 32'(ew.size()), 32'(wq.size()));
      foreach (ew[i]) chk("write", ew[i], wq[i]);
   endtask
   ////////////////////////////////////////////////////////////
   task t_multi;
      slow = 1'b1;
      run(mf(8'h11, 16'h0FA0, 16'h0002, 8'h04, '{8'h00, 8'h0A, 8'h01, 8'h02}), 1'b1,
          hd(8'h11, 8'h10, 16'h0FA0, 16'h0002), '{32'h0FA0_000A, 32'h0FA1_0102});
      $display("t_multi done");
   endtask
   task t_max;
      bq_t d;
      wq_t w;
      slow = 1'b0;
      for (int i = 0; i < 123; i++) begin
         d.push_back(8'h00);
         d.push_back(8'(i));
         w.push_back({16'h0BB8 + 16'(i), 16'(i)});
      end
      run(mf(8'h11, 16'h0BB8, 16'h007B, 8'hF6, d), 1'b1,
          hd(8'h11, 8'h10, 16'h0BB8, 16'h007B), w);
      d.push_back(8'h00);
      d.push_back(8'h01);
      run(mf(8'h11, 16'h0BB8, 16'h007C, 8'hF8, d), 1'b1, '{8'h11, 8'h90, 8'h03}, '{});
      run(mf(8'h11, 16'h0BB8, 16'h0001, 8'h03, '{8'h00, 8'h01}), 1'b1,
          '{8'h11, 8'h90, 8'h03}, '{});
      $display("t_max done");
   endtask
   task t_item;
      bq_t d;
      wq_t w;
      ADDRESS_COUNTING_SELECT = 1'b1;
      run(mf(8'h11, 16'h1B59, 16'h0001, 8'h04, '{8'h40, 8'h84, 8'h08, 8'h00}), 1'b1,
          hd(8'h11, 8'h10, 16'h1B59, 16'h0001), '{32'h1B5A_4084, 32'h1B5B_0800});
      run(hd(8'h11, 8'h06, 16'h2328, 16'h0003), 1'b1, hd(8'h11, 8'h06, 16'h2328, 16'h0003),
          '{32'h2328_0000, 32'h2329_0000, 32'h232A_0000, 32'h232B_0003});
      for (int i = 0; i < 8; i++) begin
         d.push_back(8'h41);
         d.push_back(8'(i));
         w.push_back({16'h36B0 + 16'(i), 16'h4100 + 16'(i)});
      end
      run(mf(8'h11, 16'h36B0, 16'h0001, 8'h10, d), 1'b1,
          hd(8'h11, 8'h10, 16'h36B0, 16'h0001), w);
      ADDRESS_COUNTING_SELECT = 1'b0;
      $display("t_item done");
   endtask
   task t_exc;
      bq_t fcs;
      fcs = '{8'h01, 8'h03, 8'h05, 8'h0F};
      foreach (fcs[i]) run(hd(8'h11, fcs[i], 16'h0000, 16'h0001), 1'b1,
          '{8'h11, fcs[i] | 8'h80, 8'h01}, '{});
      run(mf(8'h11, 16'h0000, 16'h0001, 8'h02, '{8'h00, 8'h01}), 1'b1,
          '{8'h11, 8'h90, 8'h02}, '{});
      run(mf(8'h11, 16'h0F9F, 16'h0002, 8'h04, '{8'h00, 8'h01, 8'h00, 8'h02}), 1'b1,
          '{8'h11, 8'h90, 8'h02}, '{});
      run(hd(8'h11, 8'h06, 16'h32C8, 16'h0001), 1'b1, '{8'h11, 8'h86, 8'h02}, '{});
      $display("t_exc done");
   endtask
   task t_quiet;
      run(mf(8'h00, 16'h0BB8, 16'h0001, 8'h02, '{8'h12, 8'h34}), 1'b1,
          '{}, '{32'h0BB8_1234});
      run(hd(8'h00, 8'h0F, 16'h0000, 16'h0001), 1'b1, '{}, '{});
      run(mf(8'h11, 16'h0BB8, 16'h0001, 8'h02, '{8'h12, 8'h34}), 1'b0, '{}, '{});
      run(mf(8'h12, 16'h0BB8, 16'h0001, 8'h02, '{8'h12, 8'h34}), 1'b1, '{}, '{});
      $display("t_quiet done");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #500_000;
      err_total++;
      test_done;
   end
   initial begin
      err_total = 0;
      n_compared = 0;
      RST_N = 1'b0;
      DEV_ADDR = 8'h11;
      ADDRESS_COUNTING_SELECT = 1'b0;
      RX_BYTE = 8'h00;
      RX_VALID = 1'b0;
      RX_END = 1'b0;
      RX_GOOD = 1'b0;
      slow = 1'b0;
      repeat (3) @(negedge SYS_CLK);
      RST_N = 1'b1;
      t_multi;
      t_max;
      t_item;
      t_exc;
      t_quiet;
      test_done;
   end
endmodule // test_fieldbus_write_handler
